// ===== rtl/sfr_pkg.sv
package sfr_pkg;
  // Memory read opcodes
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_READ4      = 8'h13;
  localparam logic [7:0] OP_FAST       = 8'h0B;
  localparam logic [7:0] OP_FAST4      = 8'h0C;
  localparam logic [7:0] OP_DOUT       = 8'h3B;
  localparam logic [7:0] OP_DOUT4      = 8'h3C;
  localparam logic [7:0] OP_DIO        = 8'hBB;
  localparam logic [7:0] OP_DIO4       = 8'hBC;
  localparam logic [7:0] OP_QOUT       = 8'h6B;
  localparam logic [7:0] OP_QOUT4      = 8'h6C;
  localparam logic [7:0] OP_QIO        = 8'hEB;
  localparam logic [7:0] OP_QIO4       = 8'hEC;
  localparam logic [7:0] OP_QWORD      = 8'hE7;
  localparam logic [7:0] OP_DTR_FAST   = 8'h0D;
  localparam logic [7:0] OP_DTR_FAST4  = 8'h0E;
  localparam logic [7:0] OP_DTR_DOUT   = 8'h3D;
  localparam logic [7:0] OP_DTR_DIO    = 8'hBD;
  localparam logic [7:0] OP_DTR_DIO4   = 8'hBE;
  localparam logic [7:0] OP_DTR_QOUT   = 8'h6D;
  localparam logic [7:0] OP_DTR_QIO    = 8'hED;
  localparam logic [7:0] OP_DTR_QIO4   = 8'hEE;
  // Latch control and register reads
  localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_CLR_FLAG   = 8'h50;
  localparam logic [7:0] OP_RD_STATUS  = 8'h05;
  localparam logic [7:0] OP_RD_FLAG    = 8'h70;
  localparam logic [7:0] OP_RD_NVCFG   = 8'hB5;
  localparam logic [7:0] OP_RD_VCFG    = 8'h85;
  localparam logic [7:0] OP_RD_EVCFG   = 8'h65;
  localparam logic [7:0] OP_RD_EXTADDR = 8'hC8;
  // Register port offsets
  localparam logic [2:0] REG_CTRL      = 3'h0;
  localparam logic [2:0] REG_STATUS    = 3'h1;
  localparam logic [2:0] REG_FLAG      = 3'h2;
  localparam logic [2:0] REG_NVCFG     = 3'h3;
  localparam logic [2:0] REG_VCFG      = 3'h4;
  localparam logic [2:0] REG_EVCFG     = 3'h5;
  localparam logic [2:0] REG_EXTADDR   = 3'h6;
  localparam logic [2:0] REG_STATE     = 3'h7;
  // Fields and reset values
  localparam int         CTRL_PROTO_LSB = 0;
  localparam int         CTRL_DTR_BIT   = 2;
  localparam int         CTRL_ADDR4_BIT = 3;
  localparam logic [3:0] CTRL_RST       = 4'h0;
  localparam int         STATUS_WEL_BIT = 1;
  localparam int         FLAG_PROT_BIT  = 1;
  localparam logic [7:0] FLAG_ERR_MASK  = 8'h3E;
  localparam logic [7:0] REG8_RST       = 8'h00;
  localparam logic [15:0] NVCFG_RST     = 16'hFFFF;
  localparam logic [3:0] CMD_BITS       = 4'h8;
  localparam logic [5:0] ADDR3_BITS     = 6'h18;
  localparam logic [5:0] ADDR4_BITS     = 6'h20;
  localparam logic [1:0] NV_ZERO_IDX    = 2'h2;

  typedef enum logic [1:0] {
    PROTO_EXT  = 2'b00,
    PROTO_DUAL = 2'b01,
    PROTO_QUAD = 2'b10
  } sfr_proto_e;

  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DUMMY = 3'b010,
    ST_DATA  = 3'b011,
    ST_REG   = 3'b100,
    ST_SKIP  = 3'b101
  } sfr_state_e;

  typedef enum logic [1:0] {
    K_BAD = 2'b00,
    K_MEM = 2'b01,
    K_REG = 2'b10,
    K_CTL = 2'b11
  } sfr_kind_e;
endpackage : sfr_pkg

// ===== rtl/sfr_cmd_front.sv
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Plain reads: command plus address ends at 7+A, 3+A/2, 1+A/4.
// - Fast reads: command plus address ends at 7+A, 3+A/2, 1+A/4.
// - Dual-output read: extended and dual only; address lanes follow protocol.
// - Dual in/out read: address carried on two lanes.
// - Quad-output read: extended and quad only; address lanes follow protocol.
// - Quad word read: address on four lanes; extended and quad only, and never with DTR enabled.
// - DTR fast read: address on both edges, lanes follow protocol.
// - DTR dual-output read: both edges, extended and dual only.
// - DTR dual in/out read: two lanes, both edges.
// - DTR quad-output read: both edges, extended and quad only.
// - DTR quad in/out read: four lanes, both edges.
// - Extra clocks after the code discard the command; latch unchanged.
// - Write enable sets the write enable latch.
// - Write disable clears latch unless protection error; clear-flag clears both.
// - Register reads use lane one in extended, lanes 1:0 dual, 3:0 quad.
// - Raising select ends any read and releases the outputs.
// - Status and flag reads are served at any time.
// - Config read gives 16 bits then zeros; reserved bits read one.
// - Config register goes out least significant byte first.
// - Volatile, enhanced and extended address reads repeat one byte.
// - Address latched on rising edges (both edges in DTR), increments per byte, wraps at boundary.
// - DTR opcodes always run DTR; others only when enabled.
// - Plain opcodes take 24-bit address unless the control 4-byte bit is set; 4-byte opcodes take 32 bits.
module sfr_cmd_front #(
  parameter int          MEM_AW     = 16,
  parameter logic [4:0]  FAST_DUMMY = 5'h08,
  parameter logic [4:0]  WORD_DUMMY = 5'h04,
  parameter logic [15:0] NV_RSVD    = 16'h0000
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              link_clk,
  input  wire logic              sel_n,
  input  wire logic [3:0]        serial_lane_in,
  output logic      [3:0]        serial_lane_out,
  output logic      [3:0]        serial_lane_oe,
  input  wire logic [2:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  output logic      [MEM_AW-1:0] mem_addr,
  input  wire logic [7:0]        mem_rd_data,
  output logic                   wel
);
  // Pin synchroniser: select idles high
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic       sck_prev;
  logic       sel_prev_n;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a     <= 6'h10;
      sync_b     <= 6'h10;
      sck_prev   <= 1'b0;
      sel_prev_n <= 1'b1;
    end else begin
      sync_a     <= {link_clk, sel_n, serial_lane_in};
      sync_b     <= sync_a;
      sck_prev   <= sync_b[5];
      sel_prev_n <= sync_b[4];
    end
  end

  logic       rise;
  logic       fall;
  logic       sel_act;
  logic [3:0] din;
  assign rise    = sync_b[5] & ~sck_prev;
  assign fall    = ~sync_b[5] & sck_prev;
  assign sel_act = ~sync_b[4];
  assign din     = sync_b[3:0];

  // Software registers
  logic [3:0]  ctrl;
  logic [7:0]  status_val;
  logic [7:0]  flag_val;
  logic [15:0] nvcfg;
  logic [7:0]  vcfg;
  logic [7:0]  evcfg;
  logic [7:0]  extaddr;
  logic        exec;
  logic        prot_err;
  logic [7:0]  op;
  sfr_pkg::sfr_state_e state;

  assign prot_err = flag_val[sfr_pkg::FLAG_PROT_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl       <= sfr_pkg::CTRL_RST;
      status_val <= sfr_pkg::REG8_RST;
      nvcfg      <= sfr_pkg::NVCFG_RST;
      vcfg       <= sfr_pkg::REG8_RST;
      evcfg      <= sfr_pkg::REG8_RST;
      extaddr    <= sfr_pkg::REG8_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        sfr_pkg::REG_CTRL:    ctrl       <= reg_wdata[3:0];
        sfr_pkg::REG_STATUS:  status_val <= reg_wdata[7:0];
        sfr_pkg::REG_NVCFG:   nvcfg      <= reg_wdata;
        sfr_pkg::REG_VCFG:    vcfg       <= reg_wdata[7:0];
        sfr_pkg::REG_EVCFG:   evcfg      <= reg_wdata[7:0];
        sfr_pkg::REG_EXTADDR: extaddr    <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Software write of the flag wins over a hardware clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_val <= sfr_pkg::REG8_RST;
    end else if (reg_wr && reg_addr == sfr_pkg::REG_FLAG) begin
      flag_val <= reg_wdata[7:0];
    end else if (exec && op == sfr_pkg::OP_CLR_FLAG) begin
      flag_val <= flag_val & ~sfr_pkg::FLAG_ERR_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        sfr_pkg::REG_CTRL:    reg_rdata <= {12'h000, ctrl};
        sfr_pkg::REG_STATUS:  reg_rdata <= {8'h00, status_val};
        sfr_pkg::REG_FLAG:    reg_rdata <= {8'h00, flag_val};
        sfr_pkg::REG_NVCFG:   reg_rdata <= nvcfg;
        sfr_pkg::REG_VCFG:    reg_rdata <= {8'h00, vcfg};
        sfr_pkg::REG_EVCFG:   reg_rdata <= {8'h00, evcfg};
        sfr_pkg::REG_EXTADDR: reg_rdata <= {8'h00, extaddr};
        default:              reg_rdata <= {4'h0, wel, state, op};
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Lanes per clock of the active protocol; illegal code acts as extended
  logic [2:0] plen;
  logic       ctl_dtr;
  logic       ctl_a4;
  assign ctl_dtr = ctrl[sfr_pkg::CTRL_DTR_BIT];
  assign ctl_a4  = ctrl[sfr_pkg::CTRL_ADDR4_BIT];
  always_comb begin
    unique case (ctrl[sfr_pkg::CTRL_PROTO_LSB +: 2])
      sfr_pkg::PROTO_DUAL: plen = 3'h2;
      sfr_pkg::PROTO_QUAD: plen = 3'h4;
      default:             plen = 3'h1;
    endcase
  end

  function automatic logic [31:0] shift_in(input logic [31:0] v,
                                           input logic [2:0]  n,
                                           input logic [3:0]  d);
    logic [31:0] r;
    r = {v[27:0], d};
    if (n == 3'h1) r = {v[30:0], d[0]};
    else if (n == 3'h2) r = {v[29:0], d[1:0]};
    return r;
  endfunction

  // Command shift and decode of the completed code
  logic [7:0]  cmd_sh;
  logic [3:0]  cmd_cnt;
  logic [31:0] cmd_wide;
  logic [7:0]  next_cmd;
  logic        cmd_done;
  assign cmd_wide = shift_in({24'h000000, cmd_sh}, plen, din);
  assign next_cmd = cmd_wide[7:0];
  assign cmd_done = state == sfr_pkg::ST_CMD && rise && sel_act &&
                    cmd_cnt + {1'b0, plen} == sfr_pkg::CMD_BITS;

  sfr_pkg::sfr_kind_e kind;
  logic [2:0] d_al;
  logic [2:0] d_dl;
  logic [4:0] d_dummy;
  logic       d_dtr;
  logic       d_a4;
  logic       is_dual;
  logic       is_quad;
  assign is_dual = plen == 3'h2;
  assign is_quad = plen == 3'h4;

  always_comb begin
    kind    = sfr_pkg::K_MEM;
    d_al    = plen;
    d_dl    = plen;
    d_dummy = FAST_DUMMY;
    d_dtr   = ctl_dtr;
    d_a4    = ctl_a4;
    unique case (next_cmd)
      sfr_pkg::OP_READ, sfr_pkg::OP_READ4: d_dummy = 5'h00;
      sfr_pkg::OP_FAST, sfr_pkg::OP_FAST4: ;
      sfr_pkg::OP_DOUT, sfr_pkg::OP_DOUT4: begin
        d_dl = 3'h2;
        if (is_quad) kind = sfr_pkg::K_BAD;
      end
      sfr_pkg::OP_DIO, sfr_pkg::OP_DIO4: begin
        d_al = 3'h2;
        d_dl = 3'h2;
        if (is_quad) kind = sfr_pkg::K_BAD;
      end
      sfr_pkg::OP_QOUT, sfr_pkg::OP_QOUT4: begin
        d_dl = 3'h4;
        if (is_dual) kind = sfr_pkg::K_BAD;
      end
      sfr_pkg::OP_QIO, sfr_pkg::OP_QIO4: begin
        d_al = 3'h4;
        d_dl = 3'h4;
        if (is_dual) kind = sfr_pkg::K_BAD;
      end
      sfr_pkg::OP_QWORD: begin
        d_al    = 3'h4;
        d_dl    = 3'h4;
        d_dummy = WORD_DUMMY;
        if (is_dual || ctl_dtr) kind = sfr_pkg::K_BAD;
      end
      sfr_pkg::OP_DTR_FAST, sfr_pkg::OP_DTR_FAST4: d_dtr = 1'b1;
      sfr_pkg::OP_DTR_DOUT: begin
        d_dtr = 1'b1;
        d_dl  = 3'h2;
        if (is_quad) kind = sfr_pkg::K_BAD;
      end
      sfr_pkg::OP_DTR_DIO, sfr_pkg::OP_DTR_DIO4: begin
        d_dtr = 1'b1;
        d_al  = 3'h2;
        d_dl  = 3'h2;
        if (is_quad) kind = sfr_pkg::K_BAD;
      end
      sfr_pkg::OP_DTR_QOUT: begin
        d_dtr = 1'b1;
        d_dl  = 3'h4;
        if (is_dual) kind = sfr_pkg::K_BAD;
      end
      sfr_pkg::OP_DTR_QIO, sfr_pkg::OP_DTR_QIO4: begin
        d_dtr = 1'b1;
        d_al  = 3'h4;
        d_dl  = 3'h4;
        if (is_dual) kind = sfr_pkg::K_BAD;
      end
      // status reads never gated by busy
      sfr_pkg::OP_RD_STATUS, sfr_pkg::OP_RD_FLAG, sfr_pkg::OP_RD_NVCFG,
      sfr_pkg::OP_RD_VCFG, sfr_pkg::OP_RD_EVCFG, sfr_pkg::OP_RD_EXTADDR:
        kind = sfr_pkg::K_REG;
      sfr_pkg::OP_WR_ENABLE, sfr_pkg::OP_WR_DISABLE, sfr_pkg::OP_CLR_FLAG:
        kind = sfr_pkg::K_CTL;
      default: kind = sfr_pkg::K_BAD;
    endcase
    unique case (next_cmd)
      sfr_pkg::OP_READ4, sfr_pkg::OP_FAST4, sfr_pkg::OP_DOUT4,
      sfr_pkg::OP_DIO4, sfr_pkg::OP_QOUT4, sfr_pkg::OP_QIO4,
      sfr_pkg::OP_DTR_FAST4, sfr_pkg::OP_DTR_DIO4, sfr_pkg::OP_DTR_QIO4:
        d_a4 = 1'b1;
      default: ;
    endcase
  end

  // Sequencer state
  logic [31:0] addr;
  logic [5:0]  abits_left;
  logic [4:0]  dummy_left;
  logic [2:0]  alanes;
  logic [2:0]  dlanes;
  logic [4:0]  dummy_q;
  logic        dtr_q;
  logic        addr_a4;
  logic        cmd_ok;
  logic [2:0]  opos;
  logic [7:0]  obyte;
  logic [1:0]  reg_idx;
  logic        in_edge;
  logic        out_edge;
  logic        addr_last;
  logic [7:0]  reg_byte;
  logic [7:0]  cur;
  logic [2:0]  next_opos;
  logic        byte_done;
  logic [31:0] next_addr;

  assign mem_addr = addr[MEM_AW-1:0];
  // rising edges, plus falling once DTR address has begun
  // Width latched with the opcode, so a 4-byte opcode skips the cmd fall
  assign in_edge  = sel_act && (rise || (dtr_q && fall &&
                    abits_left != (addr_a4 ? sfr_pkg::ADDR4_BITS
                                           : sfr_pkg::ADDR3_BITS)));
  assign out_edge = sel_act && (fall || (dtr_q && rise));
  assign addr_last = abits_left == {3'h0, alanes};
  assign next_addr = shift_in(addr, alanes, din);
  assign cur       = opos == 3'h0 ? (state == sfr_pkg::ST_DATA ? mem_rd_data
                                                               : reg_byte)
                                  : obyte;
  assign next_opos = opos + dlanes;
  assign byte_done = next_opos == 3'h0;

  always_comb begin
    unique case (op)
      sfr_pkg::OP_RD_STATUS:
        reg_byte = {status_val[7:2], wel, status_val[0]};
      sfr_pkg::OP_RD_FLAG: reg_byte = flag_val;
      // low byte, high byte, then zeros
      sfr_pkg::OP_RD_NVCFG:
        unique case (reg_idx)
          2'h0:    reg_byte = nvcfg[7:0] | NV_RSVD[7:0];
          2'h1:    reg_byte = nvcfg[15:8] | NV_RSVD[15:8];
          default: reg_byte = 8'h00;
        endcase
      sfr_pkg::OP_RD_VCFG:  reg_byte = vcfg;
      sfr_pkg::OP_RD_EVCFG: reg_byte = evcfg;
      default:              reg_byte = extaddr;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= sfr_pkg::ST_CMD;
      cmd_sh     <= 8'h00;
      cmd_cnt    <= 4'h0;
      op         <= 8'h00;
      cmd_ok     <= 1'b0;
      addr       <= 32'h00000000;
      abits_left <= 6'h00;
      dummy_left <= 5'h00;
      alanes     <= 3'h1;
      dlanes     <= 3'h1;
      dummy_q    <= 5'h00;
      dtr_q      <= 1'b0;
      addr_a4    <= 1'b0;
      opos       <= 3'h0;
      obyte      <= 8'h00;
      reg_idx    <= 2'h0;
    end else if (!sel_act) begin
      state   <= sfr_pkg::ST_CMD;
      cmd_sh  <= 8'h00;
      cmd_cnt <= 4'h0;
      dtr_q   <= 1'b0;
      opos    <= 3'h0;
      reg_idx <= 2'h0;
      cmd_ok  <= cmd_ok & sel_prev_n;
    end else begin
      unique case (state)
        sfr_pkg::ST_CMD: if (rise) begin
          cmd_sh  <= next_cmd;
          cmd_cnt <= cmd_cnt + {1'b0, plen};
          if (cmd_done) begin
            op         <= next_cmd;
            alanes     <= d_al;
            dlanes     <= d_dl;
            dummy_q    <= d_dummy;
            dummy_left <= d_dummy;
            dtr_q      <= kind == sfr_pkg::K_MEM && d_dtr;
            addr_a4    <= d_a4;
            addr       <= 32'h00000000;
            abits_left <= d_a4 ? sfr_pkg::ADDR4_BITS
                               : sfr_pkg::ADDR3_BITS;
            cmd_ok     <= kind == sfr_pkg::K_CTL;
            unique case (kind)
              sfr_pkg::K_MEM: state <= sfr_pkg::ST_ADDR;
              sfr_pkg::K_REG: state <= sfr_pkg::ST_REG;
              default:        state <= sfr_pkg::ST_SKIP;
            endcase
          end
        end
        sfr_pkg::ST_ADDR: if (in_edge) begin
          addr       <= next_addr;
          abits_left <= abits_left - {3'h0, alanes};
          if (addr_last && dummy_q == 5'h00) begin
            state <= sfr_pkg::ST_DATA;
          end else if (addr_last) begin
            state <= sfr_pkg::ST_DUMMY;
          end
        end
        sfr_pkg::ST_DUMMY: if (rise) begin
          dummy_left <= dummy_left - 5'h01;
          if (dummy_left == 5'h01) state <= sfr_pkg::ST_DATA;
        end
        sfr_pkg::ST_DATA, sfr_pkg::ST_REG: if (out_edge) begin
          obyte <= cur << dlanes;
          opos  <= next_opos;
          if (byte_done && state == sfr_pkg::ST_DATA) begin
            addr[MEM_AW-1:0] <= addr[MEM_AW-1:0] + 1'b1;
          end
          if (byte_done && reg_idx != sfr_pkg::NV_ZERO_IDX) begin
            reg_idx <= reg_idx + 2'h1;
          end
        end
        sfr_pkg::ST_SKIP: if (rise) begin
          // clocks past the code cancel it
          cmd_ok <= 1'b0;
        end
        default: state <= sfr_pkg::ST_CMD;
      endcase
    end
  end

  assign exec = sel_act == 1'b0 && sel_prev_n == 1'b0 && cmd_ok;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel <= 1'b0;
    end else if (exec) begin
      if (op == sfr_pkg::OP_WR_ENABLE) wel <= 1'b1;
      else if (op == sfr_pkg::OP_CLR_FLAG) wel <= 1'b0;
      else if (op == sfr_pkg::OP_WR_DISABLE && !prot_err) wel <= 1'b0;
    end
  end

  // Lane drivers; register reads share the data lane map
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_lane_out <= 4'h0;
      serial_lane_oe  <= 4'h0;
    end else if (!sel_act) begin
      serial_lane_out <= 4'h0;
      serial_lane_oe  <= 4'h0;
    end else if ((state == sfr_pkg::ST_DATA || state == sfr_pkg::ST_REG)
                 && out_edge) begin
      // lane one, lanes 1:0, lanes 3:0
      unique case (dlanes)
        3'h1: begin
          serial_lane_out <= {2'h0, cur[7], 1'b0};
          serial_lane_oe  <= 4'h2;
        end
        3'h2: begin
          serial_lane_out <= {2'h0, cur[7:6]};
          serial_lane_oe  <= 4'h3;
        end
        default: begin
          serial_lane_out <= cur[7:4];
          serial_lane_oe  <= 4'hF;
        end
      endcase
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  sequence wr_enable_s;
    exec && op == sfr_pkg::OP_WR_ENABLE;
  endsequence
  sequence wr_disable_s;
    exec && op == sfr_pkg::OP_WR_DISABLE;
  endsequence

  wel_set_a: assert property (
    wr_enable_s |=> wel ##1 wel)
    else $error("write enable did not set latch");
  wel_clear_a: assert property (
    wr_disable_s |=> wel == ($past(prot_err) && $past(wel)))
    else $error("write disable latch result wrong");
  overrun_drop_a: assert property (
    state == sfr_pkg::ST_SKIP && rise && sel_act |=> !cmd_ok ##1 !exec)
    else $error("overrun command not discarded");
  lane_release_a: assert property (
    !sel_act |=> serial_lane_oe == 4'h0)
    else $error("outputs not released on deselect");
  idle_return_a: assert property (
    sel_act ##1 !sel_act |=> state == sfr_pkg::ST_CMD && cmd_cnt == 4'h0)
    else $error("decoder not idle after deselect");
  addr_wrap_a: assert property (
    state == sfr_pkg::ST_DATA && out_edge && byte_done &&
    &mem_addr |=> mem_addr == '0)
    else $error("address did not wrap");
  nv_zero_a: assert property (
    state == sfr_pkg::ST_REG && op == sfr_pkg::OP_RD_NVCFG &&
    reg_idx == sfr_pkg::NV_ZERO_IDX && out_edge && sel_act
    |=> (serial_lane_out & serial_lane_oe) == 4'h0)
    else $error("config read past 16 bits not zero");
  nv_low_first_a: assert property (
    state == sfr_pkg::ST_REG && op == sfr_pkg::OP_RD_NVCFG &&
    reg_idx == 2'h0 && opos == 3'h0 && out_edge && sel_act &&
    dlanes == 3'h1 |=> serial_lane_out[1] == $past(nvcfg[7] | NV_RSVD[7]))
    else $error("config read not low byte first");
  addr_len_a: assert property (
    cmd_done && kind == sfr_pkg::K_MEM && !d_a4
    |=> abits_left == sfr_pkg::ADDR3_BITS && state == sfr_pkg::ST_ADDR)
    else $error("address length wrong");
  addr_end_a: assert property (
    state == sfr_pkg::ST_ADDR && in_edge && addr_last
    |=> state != sfr_pkg::ST_ADDR)
    else $error("address phase did not end");
  dtr_force_a: assert property (
    cmd_done && next_cmd == sfr_pkg::OP_DTR_FAST |=> dtr_q)
    else $error("DTR opcode not in DTR");
endmodule : sfr_cmd_front

// ===== testbench/sfr_host_model.sv
`timescale 1ns/1ps
module sfr_host_model (
  output logic            link_clk,
  output logic            sel_n,
  output logic [3:0]      lane_in,
  input  wire logic [3:0] lane_out,
  input  wire logic [3:0] lane_oe
);
  logic [3:0] hv;
  int         lanes;
  // Released lanes toggle so a stale bit never passes
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & hv);
  initial begin
    link_clk = 1'b0;
    sel_n    = 1'b1;
    hv       = 4'h0;
    lanes    = 1;
  end
  task automatic xfer(input logic [39:0] tx, input int nb, input int rb,
                      output logic [31:0] rx);
    rx    = '0;
    sel_n = 1'b0;
    #48;
    for (int i = 0; i < nb + rb; i++) begin
      if (i < nb) begin
        for (int k = 0; k < lanes; k++)
          hv[lanes-1-k] = lanes*i+k < 40 ? tx[39-lanes*i-k] : 1'b0;
      end else hv = ~hv;
      #24 link_clk = 1'b1;
      // lane one in extended, else all active lanes
      if (i >= nb && lanes == 1) rx = {rx[30:0], lane_in[1]};
      else if (i >= nb) rx = (rx << lanes) | (lane_in & ~(4'hF << lanes));
      #24 link_clk = 1'b0;
    end
    #24 sel_n = 1'b1;
    hv = ~hv;
    #240;
  endtask : xfer
endmodule : sfr_host_model

// ===== testbench/sfr_cmd_front_tb.sv
`timescale 1ns/1ps
module sfr_cmd_front_tb;
  logic        clk, rst, link_clk, sel_n, reg_wr, reg_rd, wel;
  logic [3:0]  lane_in, lane_out, lane_oe;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, mem_addr;
  logic [7:0]  mem_rd_data;
  logic [31:0] rx;
  int          error_cnt, n_tests, n_cyc;
  // Array stand-in: byte is a function of its address
  assign mem_rd_data = mem_addr[7:0] ^ 8'h3C;
  sfr_cmd_front #(.MEM_AW(16)) dut (.clk(clk), .rst(rst),
    .link_clk(link_clk), .sel_n(sel_n), .serial_lane_in(lane_in),
    .serial_lane_out(lane_out), .serial_lane_oe(lane_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
    .mem_rd_data(mem_rd_data), .wel(wel));
  sfr_host_model host (.link_clk(link_clk), .sel_n(sel_n),
    .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // Ceiling well above the roughly 5100 cycles the frames need
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(sfr_pkg::REG_CTRL, 16'h0000);
    rd(sfr_pkg::REG_NVCFG, 16'hFFFF);
    wr(sfr_pkg::REG_STATE, 16'hFFFF);
    rd(sfr_pkg::REG_STATE, 16'h0000);
    $display("test regs done");
    host.xfer({8'h06, 32'h0}, 9, 0, rx);
    chk({15'h0, wel}, 16'h0000);
    host.xfer({8'h06, 32'h0}, 8, 0, rx);
    chk({15'h0, wel}, 16'h0001);
    wr(sfr_pkg::REG_FLAG, 16'h0002);
    host.xfer({8'h04, 32'h0}, 8, 0, rx);
    chk({15'h0, wel}, 16'h0001);
    host.xfer({8'h50, 32'h0}, 8, 0, rx);
    chk({15'h0, wel}, 16'h0000);
    rd(sfr_pkg::REG_FLAG, 16'h0000);
    host.xfer({8'h06, 32'h0}, 8, 0, rx);
    chk({15'h0, wel}, 16'h0001);
    host.xfer({8'h04, 32'h0}, 8, 0, rx);
    chk({15'h0, wel}, 16'h0000);
    $display("test latch done");
    wr(sfr_pkg::REG_STATUS, 16'h00A6);
    host.xfer({8'h05, 32'h0}, 8, 8, rx);
    chk(rx[15:0], 16'h00A4);
    host.xfer({8'h70, 32'h0}, 8, 3, rx);
    chk({12'h0, lane_oe}, 16'h0000);
    wr(sfr_pkg::REG_NVCFG, 16'h12C4);
    host.xfer({8'hB5, 32'h0}, 8, 24, rx);
    chk(rx[23:8], 16'hC412);
    chk(rx[15:0], 16'h1200);
    wr(sfr_pkg::REG_VCFG, 16'h005A);
    host.xfer({8'h85, 32'h0}, 8, 16, rx);
    chk(rx[15:0], 16'h5A5A);
    $display("test regread done");
    host.xfer({8'h03, 24'h00FFFF, 8'h0}, 32, 16, rx);
    chk(rx[15:0], 16'hC33C);
    host.xfer({8'h13, 32'h00010002}, 40, 16, rx);
    chk(rx[15:0], 16'h3E3F);
    chk({12'h0, lane_oe}, 16'h0000);
    host.xfer({8'h0B, 24'h000040, 8'h0}, 40, 16, rx);
    chk(rx[15:0], 16'h7C7D);
    wr(sfr_pkg::REG_CTRL, 16'h0008);
    host.xfer({8'h0B, 32'h00000050}, 48, 16, rx);
    chk(rx[15:0], 16'h6C6D);
    wr(sfr_pkg::REG_CTRL, 16'h0001);
    host.lanes = 2;
    host.xfer({8'h05, 32'h0}, 4, 4, rx);
    chk(rx[15:0], 16'h00A4);
    host.xfer({8'hBB, 24'h000010, 8'h0}, 24, 8, rx);
    chk(rx[15:0], 16'h2C2D);
    wr(sfr_pkg::REG_CTRL, 16'h0002);
    host.lanes = 4;
    host.xfer({8'h6B, 24'h000020, 8'h0}, 16, 4, rx);
    chk(rx[15:0], 16'h1C1D);
    $display("test memread done");
    tally_and_finish();
  end
endmodule : sfr_cmd_front_tb
